//--- include/apso_pkg.sv
`default_nettype none
package apso_pkg;
  localparam int CODE_W    = 12;
  localparam int IN_W      = 14;
  localparam int LATENCY   = 6;
  localparam int FIFO_DEPTH = 4;
  // offset binary: signed zero sits at mid code
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] BUS_RST  = 12'h000;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } apso_word_t;
endpackage : apso_pkg
`default_nettype wire

//--- hdl/apso_fifo.sv
`default_nettype none
module apso_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    in_ready  = (cnt_r != (AW+1)'(DEPTH));
    out_valid = (cnt_r != '0);
    out_data  = mem_r[rd_r];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_nxt    = push ? inc(wr_r) : wr_r;
    rd_nxt    = pop ? inc(rd_r) : rd_r;
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; count guards every read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : apso_fifo
`default_nettype wire

//--- hdl/apso_top.sv
// Contract
// - result is 12-bit offset binary code
// - result appears six conversion edges after sampling
// - samples taken on conversion clock rising edge
// - bus driven when enable low, else released
// - sleep input high means power-down mode
// - bus bit 0 LSB, bit 11 MSB
// - out of range saturates to 0 or 4095
`default_nettype none
module apso_top #(
  parameter int IN_W = apso_pkg::IN_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        conv_clk,
  input  wire logic signed [IN_W-1:0]      sample_in,
  input  wire logic                        out_enable_n,
  input  wire logic                        sleep_request,
  output logic [apso_pkg::CODE_W-1:0]      sample_bus_o,
  output logic [apso_pkg::CODE_W-1:0]      sample_bus_oe,
  output logic                             sleeping,
  output logic                             overrun
);
  localparam int CW = apso_pkg::CODE_W;
  localparam int NS = apso_pkg::LATENCY;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers; data skew vs clock is at most one core cycle
  logic [2:0]        clk_sync_r;
  logic [1:0]        oe_sync_r, sleep_sync_r;
  logic [IN_W-1:0]   in_meta_r, in_sync_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_r   <= '0;
      oe_sync_r    <= 2'h3;
      sleep_sync_r <= 2'h0;
      in_meta_r    <= '0;
      in_sync_r    <= '0;
    end else begin
      clk_sync_r   <= {clk_sync_r[1:0], conv_clk};
      oe_sync_r    <= {oe_sync_r[0], out_enable_n};
      sleep_sync_r <= {sleep_sync_r[0], sleep_request};
      in_meta_r    <= sample_in;
      in_sync_r    <= in_meta_r;
    end
  end

  logic conv_rise, oe_n_s, sleep_s;
  assign conv_rise = clk_sync_r[1] && !clk_sync_r[2];
  assign oe_n_s    = oe_sync_r[1];
  assign sleep_s   = sleep_sync_r[1];

  //////////////////////////////////////////////////////////////////////
  // signed input to offset binary with clamping
  function automatic logic [CW-1:0] to_code(input logic signed [IN_W-1:0] v);
    logic signed [IN_W:0] s;
    s = $signed({v[IN_W-1], v}) + $signed((IN_W+1)'(apso_pkg::CODE_MID));
    if (s < 0)
      to_code = apso_pkg::CODE_MIN;
    else if (s > $signed((IN_W+1)'(apso_pkg::CODE_MAX)))
      to_code = apso_pkg::CODE_MAX;
    else
      to_code = s[CW-1:0];
  endfunction : to_code

  //////////////////////////////////////////////////////////////////////
  // conversion pipeline, one stage per rising edge
  apso_pkg::apso_word_t pipe_r [NS];
  apso_pkg::apso_word_t pipe_nxt [NS];
  logic                 fifo_in_ready, advance, overrun_nxt, overrun_r;

  // a full fifo freezes the pipe while the last stage is valid; an awake edge's sample is lost and flagged
  assign advance = conv_rise && (fifo_in_ready || !pipe_r[NS-1].valid);

  always_comb begin
    pipe_nxt    = pipe_r;
    overrun_nxt = overrun_r;
    if (advance) begin
      pipe_nxt[0].valid = !sleep_s;
      pipe_nxt[0].code  = to_code(in_sync_r);
      for (int i = 1; i < NS; i++) begin
        pipe_nxt[i] = pipe_r[i-1];
      end
    end else if (conv_rise && !sleep_s) begin
      overrun_nxt = 1'b1;
    end
    if (conv_rise && !sleep_s && advance) begin
      overrun_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        pipe_r[i] <= '0;
      end
      overrun_r <= 1'b0;
    end else begin
      pipe_r    <= pipe_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  logic          fifo_out_valid, fifo_out_ready;
  logic [CW-1:0] fifo_out_data;

  // drain stalls while asleep so the output holds its last word
  assign fifo_out_ready = !sleep_s;

  apso_fifo #(
    .W     (CW),
    .DEPTH (apso_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (advance && pipe_r[NS-1].valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pipe_r[NS-1].code),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////
  // output register and drivers
  logic [CW-1:0] bus_r, bus_nxt, oe_r, oe_nxt;
  logic          sleep_r, sleep_nxt;

  always_comb begin
    bus_nxt   = bus_r;
    if (fifo_out_valid && fifo_out_ready) begin
      bus_nxt = fifo_out_data;
    end
    oe_nxt    = oe_n_s ? '0 : '1;
    sleep_nxt = sleep_s;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r   <= apso_pkg::BUS_RST;
      oe_r    <= '0;
      sleep_r <= 1'b0;
    end else begin
      bus_r   <= bus_nxt;
      oe_r    <= oe_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  assign sample_bus_o  = bus_r;
  assign sample_bus_oe = oe_r;
  assign sleeping      = sleep_r;
  assign overrun       = overrun_r;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_edge_only;
    !conv_rise |=> $stable(pipe_r[0]);
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("pipe took a sample without a rising edge");

  property p_code_mid;
    advance && !sleep_s && in_sync_r == '0 |=> pipe_r[0].code == 12'h800;
  endproperty
  a_code_mid: assert property (p_code_mid)
    else $error("zero input is not mid code");

  property p_sat_hi;
    advance && !sleep_s && $signed(in_sync_r) > 2047
      |=> pipe_r[0].code == 12'hfff;
  endproperty
  a_sat_hi: assert property (p_sat_hi)
    else $error("over range did not saturate high");

  property p_sat_lo;
    advance && !sleep_s && $signed(in_sync_r) < -2048
      |=> pipe_r[0].code == 12'h000;
  endproperty
  a_sat_lo: assert property (p_sat_lo)
    else $error("under range did not saturate low");

  property p_stage_last;
    advance |=> pipe_r[NS-1] == $past(pipe_r[NS-2]);
  endproperty
  a_stage_last: assert property (p_stage_last)
    else $error("last stage did not follow its neighbour");

  property p_oe_on;
    !oe_n_s |=> sample_bus_oe == 12'hfff;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus not driven with enable low");

  property p_oe_off;
    oe_n_s |=> sample_bus_oe == 12'h000;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("bus driven with enable high");

  property p_sleep;
    sleep_s |=> sleeping ##0 !$changed(sample_bus_o);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("asleep but output moved or flag low");

  property p_stream;
    fifo_out_valid && !sleep_s |=> sample_bus_o == $past(fifo_out_data);
  endproperty
  a_stream: assert property (p_stream)
    else $error("output word not taken from the stream");

  c_sample:  cover property (advance && !sleep_s);
  c_full:    cover property (!fifo_in_ready);
  c_sleep:   cover property (sleep_s ##1 !sleep_s);
  c_overrun: cover property (overrun);
endmodule : apso_top
`default_nettype wire

//--- verification/apso_cap_model.sv
`default_nettype none
// capture logic: makes the conversion clock and resolves the bus
module apso_cap_model (
  input  wire logic        core_clk,
  input  wire logic        run,
  input  wire logic [11:0] bus_o,
  input  wire logic [11:0] bus_oe,
  output logic             conv_clk,
  output logic             load,
  output logic             rise,
  output logic [11:0]      bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  ph_r = 3'h4;
  logic [11:0] last_r = 12'h000;
  initial begin
    conv_clk = 1'b0;
    load = 1'b0;
    rise = 1'b0;
  end
  // released lines flip each cycle: no pull resistor on this bus
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      bus[i] = bus_oe[i] ? bus_o[i] : ~last_r[i];
    end
  end
  ////////////////////////////////////////
  // 8 core cycles per conversion, 31.25 MHz; stands low when idle
  always @(posedge core_clk) begin
    last_r <= bus;
    ph_r <= run ? ph_r + 3'h1 : 3'h4;
    conv_clk <= run && (ph_r == 3'h7 || ph_r < 3'h3);
    rise <= run && ph_r == 3'h7;
    // new input mid low phase, far from the sampling edge
    load <= run && ph_r == 3'h4;
  end
endmodule : apso_cap_model
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               run = 1'b0;
  logic               oe_n = 1'b0;
  logic               sleep_req = 1'b0;
  logic               chk_on = 1'b0;
  logic signed [13:0] smp = 14'sh0000;
  logic signed [13:0] v;
  logic               conv_clk, load, rise, sleeping, overrun;
  logic [11:0]        bus_o, bus_oe, bus, held;
  logic [11:0]        exp_q[$];
  logic signed [13:0] bnd[8] = '{-14'sh2000, -14'sh0801, -14'sh0800,
    14'sh0000, 14'sh07ff, 14'sh0800, 14'sh1fff, -14'sh0001};
  int                 err_count = 0;
  int                 check_count = 0;
  int                 k = 0;
  int                 cyc = 0;
  apso_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .conv_clk(conv_clk),
    .sample_in(smp), .out_enable_n(oe_n), .sleep_request(sleep_req),
    .sample_bus_o(bus_o), .sample_bus_oe(bus_oe), .sleeping(sleeping),
    .overrun(overrun));
  apso_cap_model cap_u (.core_clk(core_clk), .run(run), .bus_o(bus_o),
    .bus_oe(bus_oe), .conv_clk(conv_clk), .load(load), .rise(rise),
    .bus(bus));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  function automatic logic [11:0] code_of(logic signed [13:0] x);
    logic signed [13:0] t;
    t = x + 14'sh0800;
    if (x < -14'sh0800) return 12'h000;
    if (x > 14'sh07ff) return 12'hfff;
    return t[11:0];
  endfunction : code_of
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // the driver notes each expected word as it applies the input
  always @(posedge core_clk) begin
    if (load) begin
      v = (k < 8) ? bnd[k] : 14'($urandom_range(0, 4095)) - 14'sh0800;
      smp <= v;
      exp_q.push_back(code_of(v));
      k++;
    end
  end
  // latch on each rising conversion edge while checking is on and 8 words are queued; word n-7 is due there
  always @(posedge core_clk) begin
    if (rise && chk_on && exp_q.size() >= 8)
      chk("sample_bus", exp_q.pop_front(), bus);
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h0694c3c2));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_on <= 1'b1;
    run <= 1'b1;
    repeat (400) @(posedge core_clk);
    run <= 1'b0;
    oe_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("oe_off", 12'h000, bus_oe);
    oe_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("oe_on", 12'hfff, bus_oe);
    chk_on <= 1'b0;
    sleep_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("sleeping", 12'h001, {11'h000, sleeping});
    held = bus_o;
    run <= 1'b1;
    repeat (80) @(posedge core_clk);
    chk("frozen", held, bus_o);
    // asleep, a refused edge loses no sample and flags nothing
    chk("no_overrun", 12'h000, {11'h000, overrun});
    while (!rise) @(posedge core_clk);
    // wake in step with the next edge while the fifo is still full
    repeat (7) @(posedge core_clk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("overrun", 12'h001, {11'h000, overrun});
    chk("awake", 12'h000, {11'h000, sleeping});
    run <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst_bus", 12'h000, bus_o);
    chk("rst_oe", 12'h000, bus_oe);
    chk("rst_flags", 12'h000, {10'h000, sleeping, overrun});
    exp_q.delete();
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_on <= 1'b1;
    run <= 1'b1;
    repeat (160) @(posedge core_clk);
    run <= 1'b0;
    repeat (20) @(posedge core_clk);
    results();
  end
endmodule : tb
`default_nettype wire
